// *** src/pos_top.sv ***
`include "pos_consts.svh"
// Contract
// - disabled outputs go high impedance, never driven
// - controls ch0 a-d, ch3 b/d, ch4, ch6 b/d, ch7
// - per input: falling edge or 16 low samples
// - qualified fault input disables all controlled pins except ch0 pins whose hiz enable is clear
// - main oscillator stop disables all controlled pins except ch0 pins whose hiz enable is clear
// - both pair pins active one cycle: short
// - six pairs compared: 3bd 4ac 4bd 6bd 7ac 7bd
// - pair active level comes from software register
// - software request disables selected pin groups immediately
// - request bits for ch34, ch67, ch0 at b2
// - each ch0 pin has own high-impedance enable
// - 16-bit pair enables, 4bd b8 4ac b9 3bd b10
// - per input 2-bit mode field and status flag
// - input 8 forces pins only when enabled
// - per-input interrupt enables gate fault requests
// - interrupts from input sampling and short compare
// - pin select moves ch0/3/4 to alternate pins
module pos_top #(
  parameter int SAMPLE_COUNT = `POS_SAMPLE_COUNT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [4:0] shutdown_in_n,
  input wire logic osc_stop,
  input wire pos_pkg::pos_pins_t tmr_out,
  input wire pos_pkg::pos_pins_t tmr_oe_n,
  output pos_pkg::pos_pins_t pin_o,
  output pos_pkg::pos_pins_t pin_oe_n,
  output pos_pkg::pos_alt_t alt_o,
  output pos_pkg::pos_alt_t alt_oe_n,
  output logic irq
);
  localparam int CW = $clog2(SAMPLE_COUNT + 1);

  // checked at elaboration: the sample counter is sized from this count
  if (SAMPLE_COUNT < 1 || SAMPLE_COUNT > 255) begin : g_bad_count
    $error("pos_top: SAMPLE_COUNT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  logic dp_wr;
  logic [7:0] dp_addr;
  logic [31:0] mode_reg;
  logic [11:0] status;
  logic [11:0] seen;
  logic [11:0] irq_en;
  logic [5:0] active_level_cfg;
  logic [15:0] pair_hiz_enable;
  logic [2:0] sw_shutdown_request;
  logic [3:0] ch0_hiz_en;
  logic [2:0] pin_sel;
  pos_pkg::pos_pins_t hiz;

  // hsize is not decoded: every transfer is served as a whole-word access
  wire addr_ph = hsel && htrans[1] && hready;
  wire rd_ph = addr_ph && !hwrite;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `POS_OFS_MODE: rd_mux = mode_reg;
      `POS_OFS_STATUS: rd_mux = {20'h0_0000, status};
      `POS_OFS_IRQ_EN: rd_mux = {20'h0_0000, irq_en};
      `POS_OFS_ACTIVE_LVL: rd_mux = {26'h000_0000, active_level_cfg};
      `POS_OFS_PAIR_HIZ: rd_mux = {16'h0000, pair_hiz_enable};
      `POS_OFS_SW_REQ: rd_mux = {29'h0000_0000, sw_shutdown_request};
      `POS_OFS_CH0_HIZ: rd_mux = {28'h000_0000, ch0_hiz_en};
      `POS_OFS_PIN_SEL: rd_mux = {29'h0000_0000, pin_sel};
      `POS_OFS_HIZ_STATE: rd_mux = {16'h0000, hiz};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = dp_wr && (dp_addr == a);
  endfunction

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr <= addr_ph && hwrite && (haddr[31:8] == 24'h00_0000);
      dp_addr <= haddr[7:0];
    end
  end

  // unmapped reads return zero, unmapped writes are dropped; always okay
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_ph) begin
        hrdata <= (haddr[31:8] == 24'h00_0000) ? rd_mux(haddr[7:0]) : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= `POS_RST_MODE;
    end else if (wr_hit(`POS_OFS_MODE)) begin
      mode_reg <= {15'h0000, hwdata[`POS_MODE_IN8_HIZ_BIT], 6'h00, hwdata[9:0]};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en <= `POS_RST_IRQ_EN;
    end else if (wr_hit(`POS_OFS_IRQ_EN)) begin
      irq_en <= hwdata[11:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_level_cfg <= `POS_RST_ACTIVE_LVL;
    end else if (wr_hit(`POS_OFS_ACTIVE_LVL)) begin
      active_level_cfg <= hwdata[5:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pair_hiz_enable <= `POS_RST_PAIR_HIZ;
    end else if (wr_hit(`POS_OFS_PAIR_HIZ)) begin
      pair_hiz_enable <= hwdata[15:0];
    end
  end

  // request bits stay until software writes them back to zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_shutdown_request <= `POS_RST_SW_REQ;
    end else if (wr_hit(`POS_OFS_SW_REQ)) begin
      sw_shutdown_request <= hwdata[2:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ch0_hiz_en <= `POS_RST_CH0_HIZ;
    end else if (wr_hit(`POS_OFS_CH0_HIZ)) begin
      ch0_hiz_en <= hwdata[3:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sel <= `POS_RST_PIN_SEL;
    end else if (wr_hit(`POS_OFS_PIN_SEL)) begin
      pin_sel <= hwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fault inputs: three-stage synchroniser, qualified level, prescaler
  logic [4:0] s1;
  logic [4:0] s2;
  logic [4:0] s3;
  logic [4:0] lvl;
  logic [4:0] lvl_d;
  logic [2:0] osc_sync;
  logic osc_lvl;
  logic [6:0] pre;
  logic [4:0] det;

  // only the second stage reads the first, which may still be settling
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= 5'h1f;
      s2 <= 5'h1f;
      s3 <= 5'h1f;
      osc_sync <= 3'h0;
    end else begin
      s1 <= shutdown_in_n;
      s2 <= s1;
      s3 <= s2;
      osc_sync <= {osc_sync[1:0], osc_stop};
    end
  end

  // a change is accepted only once the second and third stages agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvl <= 5'h1f;
      lvl_d <= 5'h1f;
      osc_lvl <= 1'b0;
    end else begin
      lvl <= (s2 & s3) | (lvl & (s2 ^ s3));
      lvl_d <= lvl;
      if (osc_sync[1] == osc_sync[2]) begin
        osc_lvl <= osc_sync[2];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre <= 7'h00;
    end else begin
      pre <= pre + 7'h01;
    end
  end

  function automatic logic tick_of(input pos_pkg::pos_det_mode_t m, input logic [6:0] p);
    case (m)
      pos_pkg::POS_DET_DIV_A: tick_of = (p[2:0] == 3'(`POS_DIV_A - 1));
      pos_pkg::POS_DET_DIV_B: tick_of = (p[3:0] == 4'(`POS_DIV_B - 1));
      pos_pkg::POS_DET_DIV_C: tick_of = (p == 7'(`POS_DIV_C - 1));
      default: tick_of = 1'b0;
    endcase
  endfunction

  generate
    for (genvar i = 0; i < 5; i++) begin : g_in
      logic [CW-1:0] cnt;
      pos_pkg::pos_det_mode_t m;
      assign m = pos_pkg::pos_det_mode_t'(mode_reg[2*i +: 2]);
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt <= '0;
        end else if (m == pos_pkg::POS_DET_EDGE || lvl[i]) begin
          cnt <= '0;
        end else if (tick_of(m, pre) && cnt != CW'(SAMPLE_COUNT)) begin
          cnt <= cnt + CW'(1);
        end
      end
      // edge mode fires once per fall; level mode fires while the run is qualified
      assign det[i] = (m == pos_pkg::POS_DET_EDGE) ? (lvl_d[i] && !lvl[i]) :
                      (cnt == CW'(SAMPLE_COUNT));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // short-circuit compare on the six complementary pairs
  logic [5:0] pa;
  logic [5:0] pb;
  logic [5:0] shorted;
  assign pa = {tmr_out.ch7[1], tmr_out.ch7[0], tmr_out.ch6[0],
               tmr_out.ch4[0], tmr_out.ch4[1], tmr_out.ch3[0]};
  assign pb = {tmr_out.ch7[3], tmr_out.ch7[2], tmr_out.ch6[1],
               tmr_out.ch4[2], tmr_out.ch4[3], tmr_out.ch3[1]};
  // pair order: 0=3bd 1=4bd 2=4ac 3=6bd 4=7ac 5=7bd
  assign shorted = ~(pa ^ active_level_cfg) & ~(pb ^ active_level_cfg);

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status, read-before-clear, interrupt
  logic [11:0] ev;
  logic [11:0] cause;
  logic [11:0] clr;
  assign ev = {osc_lvl, shorted, det};
  assign cause = {osc_lvl, shorted, ~lvl};
  // a clear only takes for a flag that was read as set and whose cause is gone
  // a process, not an assign, so that the bus decode inside the function is seen
  always_comb begin
    clr = 12'h000;
    if (wr_hit(`POS_OFS_CLEAR)) begin
      clr = hwdata[11:0] & seen & ~cause;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= 12'h000;
    end else begin
      // set wins: an event in the clearing cycle keeps its flag
      status <= (status & ~clr) | ev;
    end
  end

  // a status read remembers which flags software has seen
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen <= 12'h000;
    end else if (rd_ph && haddr == 32'(`POS_OFS_STATUS)) begin
      seen <= status;
    end else begin
      seen <= seen & ~clr;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // high-impedance decision per pin
  logic in_all;
  logic [5:0] pair_off;
  logic [5:0] pair_en;
  pos_pkg::pos_pins_t next_hiz;
  assign in_all = |(status[4:0] & {2'h3, mode_reg[`POS_MODE_IN8_HIZ_BIT], 2'h3}) |
                  status[`POS_ST_OSC_BIT];
  // enable bits run 4bd 4ac 3bd 6bd 7ac 7bd; reorder them to the status pair order
  assign pair_en = {pair_hiz_enable[`POS_PAIR_HIZ_LSB + 5],
                    pair_hiz_enable[`POS_PAIR_HIZ_LSB + 4],
                    pair_hiz_enable[`POS_PAIR_HIZ_LSB + 3],
                    pair_hiz_enable[`POS_PAIR_HIZ_LSB + 1],
                    pair_hiz_enable[`POS_PAIR_HIZ_LSB],
                    pair_hiz_enable[`POS_PAIR_HIZ_LSB + 2]};
  assign pair_off = status[`POS_ST_PAIR_LSB +: 6] & pair_en;

  always_comb begin
    next_hiz.ch0 = {4{in_all || sw_shutdown_request[`POS_SW_CH0_BIT]}} & ch0_hiz_en;
    next_hiz.ch3 = {2{in_all || sw_shutdown_request[`POS_SW_CH34_BIT] || pair_off[0]}};
    next_hiz.ch4[0] = in_all || sw_shutdown_request[`POS_SW_CH34_BIT] || pair_off[2];
    next_hiz.ch4[2] = next_hiz.ch4[0];
    next_hiz.ch4[1] = in_all || sw_shutdown_request[`POS_SW_CH34_BIT] || pair_off[1];
    next_hiz.ch4[3] = next_hiz.ch4[1];
    next_hiz.ch6 = {2{in_all || sw_shutdown_request[`POS_SW_CH67_BIT] || pair_off[3]}};
    next_hiz.ch7[0] = in_all || sw_shutdown_request[`POS_SW_CH67_BIT] || pair_off[4];
    next_hiz.ch7[2] = next_hiz.ch7[0];
    next_hiz.ch7[1] = in_all || sw_shutdown_request[`POS_SW_CH67_BIT] || pair_off[5];
    next_hiz.ch7[3] = next_hiz.ch7[1];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hiz <= '1;
    end else begin
      hiz <= next_hiz;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers: oe low means driven; a moved channel releases its primary pins
  pos_pkg::pos_pins_t moved;
  pos_pkg::pos_pins_t next_oe_n;
  assign moved = '{ch7: 4'h0, ch6: 2'h0,
                   ch4: {4{pin_sel[`POS_SEL_CH4_BIT]}},
                   ch3: {2{pin_sel[`POS_SEL_CH3_BIT]}},
                   ch0: {4{pin_sel[`POS_SEL_CH0_BIT]}}};
  assign next_oe_n = tmr_oe_n | next_hiz;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_o <= '0;
      pin_oe_n <= '1;
      alt_o <= '0;
      alt_oe_n <= '1;
    end else begin
      pin_o <= tmr_out;
      pin_oe_n <= next_oe_n | moved;
      alt_o <= '{ch4: tmr_out.ch4, ch3: tmr_out.ch3, ch0: tmr_out.ch0};
      alt_oe_n <= '{ch4: next_oe_n.ch4 | ~moved.ch4,
                    ch3: next_oe_n.ch3 | ~moved.ch3,
                    ch0: next_oe_n.ch0 | ~moved.ch0};
    end
  end

endmodule // pos_top

// *** src/pos_consts.svh ***
`ifndef POS_CONSTS_SVH
`define POS_CONSTS_SVH
// register byte offsets
`define POS_OFS_MODE 8'h00
`define POS_OFS_STATUS 8'h04
`define POS_OFS_CLEAR 8'h08
`define POS_OFS_IRQ_EN 8'h0c
`define POS_OFS_ACTIVE_LVL 8'h10
`define POS_OFS_PAIR_HIZ 8'h14
`define POS_OFS_SW_REQ 8'h18
`define POS_OFS_CH0_HIZ 8'h1c
`define POS_OFS_PIN_SEL 8'h20
`define POS_OFS_HIZ_STATE 8'h24
// field positions
`define POS_MODE_IN8_HIZ_BIT 16
`define POS_ST_PAIR_LSB 5
`define POS_ST_OSC_BIT 11
`define POS_PAIR_HIZ_LSB 8
`define POS_SW_CH34_BIT 0
`define POS_SW_CH67_BIT 1
`define POS_SW_CH0_BIT 2
`define POS_SEL_CH0_BIT 0
`define POS_SEL_CH3_BIT 1
`define POS_SEL_CH4_BIT 2
`define POS_IN8_IDX 2
// reset values
`define POS_RST_MODE 32'h0000_0000
`define POS_RST_IRQ_EN 12'h000
`define POS_RST_ACTIVE_LVL 6'h00
`define POS_RST_PAIR_HIZ 16'h0000
`define POS_RST_SW_REQ 3'h0
`define POS_RST_CH0_HIZ 4'h0
`define POS_RST_PIN_SEL 3'h0
// timing counts
`define POS_SAMPLE_COUNT 16
`define POS_DIV_A 8
`define POS_DIV_B 16
`define POS_DIV_C 128
`endif

// *** src/pos_pkg.sv ***
package pos_pkg;
  // controlled timer pins; within a channel a=0 b=1 c=2 d=3, pair channels b=0 d=1
  typedef struct packed {
    logic [3:0] ch7;
    logic [1:0] ch6;
    logic [3:0] ch4;
    logic [1:0] ch3;
    logic [3:0] ch0;
  } pos_pins_t;
  // alternate physical pins for the channels with a pin select
  typedef struct packed {
    logic [3:0] ch4;
    logic [1:0] ch3;
    logic [3:0] ch0;
  } pos_alt_t;
  typedef enum logic [1:0] {
    POS_DET_EDGE = 2'b00,
    POS_DET_DIV_A = 2'b01,
    POS_DET_DIV_B = 2'b10,
    POS_DET_DIV_C = 2'b11
  } pos_det_mode_t;
endpackage

// *** tb/pos_far_model.sv ***
module pos_far_model (
  input wire logic clk,
  input wire logic [4:0] fault_n,
  input wire logic osc,
  input wire logic short7,
  input wire logic short3,
  output pos_pkg::pos_pins_t tmr_out,
  output pos_pkg::pos_pins_t tmr_oe_n,
  output logic [4:0] shutdown_in_n,
  output logic osc_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  logic t = 1'b0;
  always @(posedge clk) begin
    t <= ~t;
  end
  // pair members stay complementary so no short shows unless one is commanded
  assign tmr_out = {~t, (short7 ? t : ~t), t, t, ~t, t, ~t, ~t, t, t,
                    (short3 ? t : ~t), t, t, ~t, t, ~t};
  // timer always wants to drive, so every hi-z comes from the block
  assign tmr_oe_n = '0;
  assign shutdown_in_n = fault_n;
  assign osc_stop = osc;
endmodule // pos_far_model

// *** tb/pos_top_chk.sv ***
`include "pos_consts.svh"
module pos_top_chk #(
  parameter int SAMPLE_COUNT = `POS_SAMPLE_COUNT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [4:0] shutdown_in_n,
  input wire logic osc_stop,
  input wire pos_pkg::pos_pins_t tmr_out,
  input wire pos_pkg::pos_pins_t tmr_oe_n,
  input wire pos_pkg::pos_pins_t pin_o,
  input wire pos_pkg::pos_pins_t pin_oe_n,
  input wire pos_pkg::pos_alt_t alt_oe_n
);
  logic ph;
  logic [7:0] pa;
  // write data phase tracker
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph <= 1'b0;
      pa <= 8'h00;
    end else begin
      ph <= hsel && htrans[1] && hready && hwrite;
      pa <= haddr[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rst_hiz_a: assert property ($fell(sys_rst) |-> &pin_oe_n && &alt_oe_n)
    else $error("pins driven right after reset");
  osc_hiz_a: assert property ($rose(osc_stop) |-> ##[1:12] (&pin_oe_n.ch7 && &pin_oe_n.ch4))
    else $error("oscillator stop did not release pins");
  edge_hiz_a: assert property ($fell(shutdown_in_n[1]) |-> ##[1:12] (&pin_oe_n.ch3 && &pin_oe_n.ch6))
    else $error("fault edge did not release pins");
  hold_hiz_a: assert property ($rose(pin_oe_n.ch4[0]) && !tmr_oe_n.ch4[0] |=> pin_oe_n.ch4[0] [*2])
    else $error("hi-z dropped too soon");
  pin_follow_a: assert property (!pin_oe_n.ch7[0] |-> pin_o.ch7[0] == $past(tmr_out.ch7[0]))
    else $error("driven pin does not follow timer");
  alt_excl_a: assert property (!alt_oe_n.ch4[0] |-> pin_oe_n.ch4[0])
    else $error("primary and alternate pin both driven");
  sw_hiz_a: assert property (ph && pa == `POS_OFS_SW_REQ && hwdata[0]
    |-> ##[1:3] (&pin_oe_n.ch3 && &pin_oe_n.ch4))
    else $error("software request did not release pins");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
endmodule // pos_top_chk
bind pos_top pos_top_chk #(.SAMPLE_COUNT(SAMPLE_COUNT)) pos_top_chk_inst (.clk, .sys_rst, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .shutdown_in_n, .osc_stop,
  .tmr_out, .tmr_oe_n, .pin_o, .pin_oe_n, .alt_oe_n);

// *** tb/pos_top_tb.sv ***
module pos_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, irq, osc_stop;
  logic [4:0] fault_n = 5'h1f;
  logic osc = 1'b0;
  logic short7 = 1'b0;
  logic short3 = 1'b0;
  logic [4:0] shutdown_in_n;
  pos_pkg::pos_pins_t tmr_out, tmr_oe_n, pin_o, pin_oe_n;
  pos_pkg::pos_alt_t alt_o, alt_oe_n;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  pos_far_model pos_far_model_inst (.clk, .fault_n, .osc, .short7, .short3, .tmr_out, .tmr_oe_n,
    .shutdown_in_n, .osc_stop);
  pos_top pos_top_inst (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .shutdown_in_n, .osc_stop, .tmr_out,
    .tmr_oe_n, .pin_o, .pin_oe_n, .alt_o, .alt_oe_n, .irq);
  ////////////////////
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // single word transfer; waits on the slave's ready, never a fixed count
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  ////////////////////
  task t_regs;
    xfer(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, 8'h14, 32'hffff_ffff);
    xfer(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0000_ffff);
    xfer(1'b1, 8'h14, 32'h0);
    xfer(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_sw;
    xfer(1'b1, 8'h1c, 32'hf);
    xfer(1'b1, 8'h18, 32'h4);
    xfer(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h4);
    chk(pin_oe_n, 32'h000f);
    xfer(1'b1, 8'h18, 32'h1);
    repeat (3) @(posedge clk);
    chk(pin_oe_n, 32'h03f0);
    xfer(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h03f0);
    xfer(1'b1, 8'h18, 32'h0);
    xfer(1'b1, 8'h20, 32'h4);
    repeat (3) @(posedge clk);
    chk(alt_oe_n, 32'h03f);
    chk(pin_oe_n, 32'h03c0);
    xfer(1'b1, 8'h20, 32'h0);
    repeat (3) @(posedge clk);
    chk(pin_oe_n, 32'h0);
  endtask
  task t_edge;
    xfer(1'b1, 8'h0c, 32'h2);
    fault_n[1] <= 1'b0;
    repeat (12) @(posedge clk);
    chk(irq, 32'h1);
    chk(pin_oe_n, 32'hffff);
    // clear before any status read must be refused
    xfer(1'b1, 8'h08, 32'h2);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h2);
    fault_n[1] <= 1'b1;
    repeat (10) @(posedge clk);
    chk(pin_oe_n, 32'hffff);
    xfer(1'b1, 8'h08, 32'h2);
    repeat (3) @(posedge clk);
    chk(irq, 32'h0);
    chk(pin_oe_n, 32'h0);
  endtask
  task t_level;
    xfer(1'b1, 8'h00, 32'h1);
    fault_n[0] <= 1'b0;
    repeat (100) @(posedge clk);
    fault_n[0] <= 1'b1;
    repeat (10) @(posedge clk);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    fault_n[0] <= 1'b0;
    repeat (180) @(posedge clk);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 32'h0);
    chk(pin_oe_n, 32'hffff);
    fault_n[0] <= 1'b1;
    repeat (10) @(posedge clk);
    xfer(1'b1, 8'h08, 32'h1);
    repeat (3) @(posedge clk);
    chk(pin_oe_n, 32'h0);
  endtask
  task t_in8;
    fault_n[2] <= 1'b0;
    repeat (12) @(posedge clk);
    chk(pin_oe_n, 32'h0);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h4);
    fault_n[2] <= 1'b1;
    repeat (10) @(posedge clk);
    xfer(1'b1, 8'h08, 32'h4);
    xfer(1'b1, 8'h00, 32'h0001_0001);
    fault_n[2] <= 1'b0;
    repeat (12) @(posedge clk);
    chk(pin_oe_n, 32'hffff);
    fault_n[2] <= 1'b1;
    repeat (10) @(posedge clk);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h4);
    xfer(1'b1, 8'h08, 32'h4);
    repeat (3) @(posedge clk);
    chk(pin_oe_n, 32'h0);
  endtask
  task t_short;
    xfer(1'b1, 8'h10, 32'h11);
    xfer(1'b1, 8'h14, 32'h1400);
    short7 <= 1'b1;
    short3 <= 1'b1;
    repeat (6) @(posedge clk);
    chk(pin_oe_n, 32'h5030);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h220);
    short7 <= 1'b0;
    short3 <= 1'b0;
    xfer(1'b1, 8'h08, 32'h220);
    repeat (3) @(posedge clk);
    chk(pin_oe_n, 32'h0);
  endtask
  task t_osc;
    osc <= 1'b1;
    repeat (12) @(posedge clk);
    chk(pin_oe_n, 32'hffff);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h800);
  endtask
  ////////////////////
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_sw();
    t_edge();
    t_level();
    t_in8();
    t_short();
    t_osc();
    stop_test();
  end
endmodule // pos_top_tb
